// ===== ssfc_top.sv
// Purpose: realtime monitor flags, sticky error status, protected fault config
// Assumes: APB slave with zero wait states; monitor pins asynchronous
// Notes: event inputs are one-cycle pulses from logic on pclk
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module ssfc_top
(
    input logic pclk,
    input logic presetn,
    input logic [ssfc_pkg::ADDR_W-1:0] paddr,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic conv_two_current_limit_now,
    input logic conv_one_current_limit_now,
    input logic thermal_shutdown_now,
    input logic conv_two_undervoltage_now,
    input logic conv_one_undervoltage_now,
    input logic [3:0] ext_monitor_undervoltage_now,
    input logic conv_two_overvoltage_now,
    input logic conv_one_overvoltage_now,
    input logic [3:0] ext_monitor_overvoltage_now,
    input logic fault_input_one,
    input logic fault_input_two,
    input logic error_monitor_one_in,
    input logic error_monitor_two_in,
    input logic wd_closed_write,
    input logic wd_timeout,
    input logic wd_bad_answer,
    input logic bus_crc_error,
    input logic bus_request_error,
    output logic irq
);
    import ssfc_pkg::*;

    logic [15:0] rt_raw;
    logic [15:0] rt_s1_r;
    logic [15:0] rt_r;
    logic [1:0] em_s1_r;
    logic [1:0] em_r;
    logic [15:0] sts_r;
    logic [15:0] sts_nxt;
    logic [15:0] sts_set;
    logic [15:0] clr_v;
    logic [15:0] cfg_r;
    logic [15:0] ncfg_r;
    logic [15:0] mask_r;
    logic [31:0] prdata_r;
    logic [15:0] rd_word;
    logic irq_r;
    logic setup;
    logic access;
    logic wr_en;
    logic [1:0] age_r;
    logic age_ok;

    ssfc_cfg_if cfg_bus ();

    ssfc_fault_eval u_eval (
        .pclk(pclk),
        .presetn(presetn),
        .fault_input_one(fault_input_one),
        .fault_input_two(fault_input_two),
        .cb(cfg_bus.eval)
    );

    // Word-aligned offsets that exist in the map
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        logic ok;
        ok = 1'b0;
        if (a == OFS_RT || a == OFS_STS || a == OFS_CFG)
            ok = 1'b1;
        if (a == OFS_NCFG || a == OFS_MASK || a == OFS_APPLIED)
            ok = 1'b1;
        return ok;
    endfunction

    // APB phase decode; every access completes without wait states
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr_en = access & pwrite & addr_ok(paddr);
    assign pready = 1'b1;
    assign pslverr = access & ~addr_ok(paddr);

    // Realtime vector in register layout
    assign rt_raw = {1'b0,
        conv_two_current_limit_now, // [R1]
        conv_one_current_limit_now,
        thermal_shutdown_now, // [R2]
        conv_two_undervoltage_now, // [R3]
        conv_one_undervoltage_now,
        ext_monitor_undervoltage_now,
        conv_two_overvoltage_now, // [R4]
        conv_one_overvoltage_now,
        ext_monitor_overvoltage_now};

    // Realtime flags track the pins through two flops, no latching
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rt_s1_r <= RT_RST;
            rt_r <= RT_RST; // [R5]
        end
        else
        begin
            rt_s1_r <= rt_raw;
            rt_r <= rt_s1_r; // [R1] [R2] [R3] [R4]
        end
    end

    // Error monitor pins are asynchronous levels
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            em_s1_r <= 2'h0;
            em_r <= 2'h0;
        end
        else
        begin
            em_s1_r <= {error_monitor_two_in, error_monitor_one_in};
            em_r <= em_s1_r;
        end
    end

    // Status set sources; a fault level keeps re-setting its bit
    always_comb
    begin
        sts_set = 16'h0000;
        sts_set[STS_IN2] = cfg_bus.input_two_fault; // [R6]
        sts_set[STS_IN1] = cfg_bus.input_one_fault; // [R6]
        sts_set[STS_PAIR] = cfg_bus.pair_fault; // [R6]
        sts_set[STS_EM2] = em_r[1]; // [R6]
        sts_set[STS_EM1] = em_r[0]; // [R6]
        sts_set[STS_WD_TIME] = wd_closed_write | wd_timeout; // [R7]
        sts_set[STS_WD_ANS] = wd_bad_answer; // [R8]
        sts_set[STS_CRC] = bus_crc_error; // [R9]
        sts_set[STS_REQ] = bus_request_error; // [R10]
    end

    // Write-one-to-clear; a same-cycle set wins so no event is lost
    assign clr_v = (wr_en && paddr == OFS_STS) ? (pwdata[15:0] & STS_MASK) : 16'h0000;
    assign sts_nxt = (sts_r & ~clr_v) | sts_set;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sts_r <= STS_RST; // [R5]
        else
            sts_r <= sts_nxt;
    end

    // Config and complement; only defined fields are stored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_r <= CFG_RST; // [R5]
            ncfg_r <= NCFG_RST;
        end
        else
        begin
            if (wr_en && paddr == OFS_CFG)
                cfg_r <= pwdata[15:0] & CFG_MASK;
            if (wr_en && paddr == OFS_NCFG)
                ncfg_r <= pwdata[15:0] & CFG_MASK; // [R16]
        end
    end
    assign cfg_bus.cfg_fields = cfg_fields(cfg_r);
    assign cfg_bus.cmp_fields = cfg_fields(ncfg_r); // [R15]

    // Interrupt mask, same layout as status
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_r <= MASK_RST;
        else if (wr_en && paddr == OFS_MASK)
            mask_r <= pwdata[15:0] & STS_MASK;
    end

    // Registered interrupt keeps the output glitch free, one cycle late
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_r <= 1'b0;
        else
            irq_r <= |(sts_r & mask_r);
    end
    assign irq = irq_r;

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        rd_word = 16'h0000;
        case (paddr)
            OFS_RT: rd_word = rt_r & RT_MASK;
            OFS_STS: rd_word = sts_r;
            OFS_CFG: rd_word = cfg_r;
            OFS_NCFG: rd_word = ncfg_r;
            OFS_MASK: rd_word = mask_r;
            OFS_APPLIED:
            begin
                rd_word[POS_PAIR_POL] = cfg_bus.applied[F_PAIR_POL];
                rd_word[POS_POL1] = cfg_bus.applied[F_POL1];
                rd_word[POS_POL2] = cfg_bus.applied[F_POL2];
                rd_word[POS_BIST] = cfg_bus.applied[F_BIST];
            end
            default: rd_word = 16'h0000;
        endcase
    end

    // Read data captured in setup so it leaves a flop in access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= 32'h0000_0000;
        else if (setup && !pwrite)
            prdata_r <= {16'h0000, rd_word};
    end
    assign prdata = prdata_r;

    // Helper for checks: pipeline depth filled after reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            age_r <= 2'h0;
        else if (age_r != 2'h3)
            age_r <= age_r + 2'h1;
    end
    assign age_ok = (age_r == 2'h3);

    property p_rt_bits(logic [15:0] m);
        @(posedge pclk) disable iff (!presetn)
        age_ok |-> ((rt_r ^ $past(rt_raw, 2)) & m) == 16'h0000;
    endproperty

    AST_RT_ILIM: assert property (p_rt_bits(16'h6000)) // [R1]
        else $error("current limit flags do not track inputs");
    AST_RT_TSD: assert property (p_rt_bits(16'h1000)) // [R2]
        else $error("thermal shutdown flag does not track input");
    AST_RT_UV: assert property (p_rt_bits(16'h0FC0)) // [R3]
        else $error("undervoltage flags do not track inputs");
    AST_RT_OV: assert property (p_rt_bits(16'h003F)) // [R4]
        else $error("overvoltage flags do not track inputs");

    // Bits fall only through a written one
    AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
        (~sts_r & $past(sts_r) & ~$past(clr_v)) == 16'h0000)
        else $error("status bit fell without a clear");

    // A cleared bit with no new event reads zero
    AST_W1C: assert property (@(posedge pclk) disable iff (!presetn)
        (clr_v & ~sts_set) != 16'h0000 |=> (sts_r & $past(clr_v & ~sts_set)) == 16'h0000)
        else $error("written one did not clear status");

    // Event and clear together: the event wins
    AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
        (sts_set & clr_v) != 16'h0000 |=> (~sts_r & $past(sts_set)) == 16'h0000)
        else $error("same-cycle clear lost an event");

    // Reset-level pins look faulty; wait for the pipe
    AST_FAULT_SET: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        age_ok && (cfg_bus.input_one_fault || cfg_bus.pair_fault)
        |=> sts_r[STS_IN1] || sts_r[STS_PAIR])
        else $error("fault input did not set status");

    // Input two in independent mode
    AST_FAULT_TWO: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        age_ok && cfg_bus.input_two_fault |=> sts_r[STS_IN2])
        else $error("fault input two did not set status");

    // Error monitor two after its synchroniser
    AST_EM_SET: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        age_ok && $past(error_monitor_two_in, 2) |-> ##1 sts_r[STS_EM2])
        else $error("error monitor two did not set status");

    // Error monitor one after its synchroniser
    AST_EM_ONE: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        age_ok && $past(error_monitor_one_in, 2) |-> ##1 sts_r[STS_EM1])
        else $error("error monitor one did not set status");

    // Closed-window write or refresh timeout
    AST_WD_TIMING: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        wd_closed_write || wd_timeout |=> sts_r[STS_WD_TIME])
        else $error("watchdog timing error not flagged");

    // Wrong watchdog answer
    AST_WD_ANSWER: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        wd_bad_answer |=> sts_r[STS_WD_ANS])
        else $error("watchdog answer error not flagged");

    // Checksum error on its own bit
    AST_CRC: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        bus_crc_error |=> sts_r[STS_CRC])
        else $error("checksum error not flagged");

    // Invalid request on its own bit
    AST_REQ: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        bus_request_error |=> sts_r[STS_REQ])
        else $error("request error not flagged");

    // Interrupt follows pending unmasked status
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        (sts_r & mask_r) != 16'h0000 |=> irq)
        else $error("interrupt not raised for unmasked status");

    // No interrupt with nothing pending
    AST_IRQ_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        (sts_r & mask_r) == 16'h0000 |=> !irq)
        else $error("interrupt raised with nothing pending");

    // Config write keeps defined fields only
    AST_CFG_STORE: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
        wr_en && paddr == OFS_CFG |=> cfg_r == ($past(pwdata[15:0]) & CFG_MASK))
        else $error("config write not stored");

    // Complement write keeps defined fields only
    AST_CFG_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
        wr_en && paddr == OFS_NCFG |=> ncfg_r == ($past(pwdata[15:0]) & CFG_MASK))
        else $error("complement write not stored");

    // Mask write keeps status layout
    AST_MASK_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_MASK |=> mask_r == ($past(pwdata[15:0]) & STS_MASK))
        else $error("mask write not stored");

    // Status read data launched from the setup edge
    AST_RD_STS: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == OFS_STS |=> prdata == {16'h0000, $past(sts_r)})
        else $error("status read data wrong");

    // A refused access stores nothing
    AST_ERR_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |=> cfg_r == $past(cfg_r) && ncfg_r == $past(ncfg_r) && mask_r == $past(mask_r))
        else $error("refused write changed a register");

    COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    COV_CLEAR: cover property (@(posedge pclk) disable iff (!presetn)
        (clr_v & sts_r) != 16'h0000);
    COV_APPLY: cover property (@(posedge pclk) disable iff (!presetn)
        $changed(cfg_bus.applied));
    COV_SLVERR: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule

// ===== ssfc_pkg.sv
// Purpose: shared constants for the safety status and fault input block
// Assumes: APB data 32 bits, registers 16 bits wide in the low half
// Notes: offsets are byte addresses, one aligned word per register
// Contract
// R1 - Realtime bits 14 and 13 show converter two and one current limit now.
// R2 - Realtime bit 12 shows thermal shutdown detected now.
// R3 - Realtime undervoltage: bit 11 conv two, 10 conv one, 9..6 monitors four..one.
// R4 - Realtime overvoltage: bit 5 conv two, 4 conv one, 3..0 monitors four..one.
// R5 - Flags and config fields return to defaults only on power-on reset.
// R6 - Status bits 14, 13, 12, 9, 8 set on input two, one, pair, monitors.
// R7 - Status bit 5 sets on closed-window answer write or refresh timeout.
// R8 - Status bit 4 sets on a wrong watchdog answer value.
// R9 - Status bit 1 sets on a serial-bus write with bad checksum.
// R10 - Status bit 0 sets on an invalid serial-bus request.
// R11 - Pair polarity bit 14: 0 one low or two high faults, 1 inverse.
// R12 - Input one polarity bit 13: 0 low level faults, 1 high level faults.
// R13 - Input two polarity bit 12: 0 low level faults, 1 high level faults.
// R14 - Config bit 8 picks independent inputs (0) or bistable pair (1).
// R15 - A setting applies only when it equals the inverse of its complement.
// R16 - Complement register holds inverted fields at bits 14, 13, 12 and 8.
// R17 - On mismatch the previously applied setting stays in force.
package ssfc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_RT = 8'h00;
    localparam logic [7:0] OFS_STS = 8'h04;
    localparam logic [7:0] OFS_CFG = 8'h08;
    localparam logic [7:0] OFS_NCFG = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_APPLIED = 8'h14;
    localparam int unsigned POS_PAIR_POL = 14;
    localparam int unsigned POS_POL1 = 13;
    localparam int unsigned POS_POL2 = 12;
    localparam int unsigned POS_BIST = 8;
    localparam int unsigned STS_IN2 = 14;
    localparam int unsigned STS_IN1 = 13;
    localparam int unsigned STS_PAIR = 12;
    localparam int unsigned STS_EM2 = 9;
    localparam int unsigned STS_EM1 = 8;
    localparam int unsigned STS_WD_TIME = 5;
    localparam int unsigned STS_WD_ANS = 4;
    localparam int unsigned STS_CRC = 1;
    localparam int unsigned STS_REQ = 0;
    localparam logic [15:0] STS_MASK = 16'h7333;
    localparam logic [15:0] RT_MASK = 16'h7FFF;
    localparam logic [15:0] CFG_MASK = 16'h7100;
    localparam logic [15:0] RT_RST = 16'h0000;
    localparam logic [15:0] STS_RST = 16'h0000;
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [15:0] NCFG_RST = 16'h7100;
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [3:0] APPLIED_RST = 4'h0;
    localparam int unsigned F_PAIR_POL = 3;
    localparam int unsigned F_POL1 = 2;
    localparam int unsigned F_POL2 = 1;
    localparam int unsigned F_BIST = 0;

    // Gather the four config fields into a compact vector
    function automatic logic [3:0] cfg_fields(input logic [15:0] r);
        return {r[POS_PAIR_POL], r[POS_POL1], r[POS_POL2], r[POS_BIST]};
    endfunction
endpackage

// ===== ssfc_cfg_if.sv
// Purpose: carries config fields and fault results between regs and evaluator
// Assumes: single clock domain
// Notes: field order follows the F_* indices of the package
`timescale 1ns/1ps
interface ssfc_cfg_if;
    logic [3:0] cfg_fields;
    logic [3:0] cmp_fields;
    logic [3:0] applied;
    logic input_one_fault;
    logic input_two_fault;
    logic pair_fault;
    modport regs (output cfg_fields, output cmp_fields, input applied,
        input input_one_fault, input input_two_fault, input pair_fault);
    modport eval (input cfg_fields, input cmp_fields, output applied,
        output input_one_fault, output input_two_fault, output pair_fault);
endinterface

// ===== ssfc_fault_eval.sv
// Purpose: synchronise fault inputs, apply protected config, evaluate faults
// Assumes: fault pins are asynchronous to pclk
// Notes: fault results are levels, recomputed every cycle
`timescale 1ns/1ps
module ssfc_fault_eval
(
    input logic pclk,
    input logic presetn,
    input logic fault_input_one,
    input logic fault_input_two,
    ssfc_cfg_if.eval cb
);
    import ssfc_pkg::*;

    logic [1:0] pin_s1_r;
    logic [1:0] pin_r;
    logic [3:0] applied_r;
    logic [3:0] match;
    logic one_bad;
    logic two_bad;
    logic pair_bad;

    // Two-stage synchroniser, first stage read by second only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1_r <= 2'h0;
            pin_r <= 2'h0;
        end
        else
        begin
            pin_s1_r <= {fault_input_two, fault_input_one};
            pin_r <= pin_s1_r;
        end
    end

    // Per-field apply; a torn write can change the matching fields while the others hold
    assign match = cb.cfg_fields ^ cb.cmp_fields;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            applied_r <= APPLIED_RST; // [R5]
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (match[i])
                    applied_r[i] <= cb.cfg_fields[i]; // [R15] [R16]
            end // Mismatch keeps old field [R17]
        end
    end
    assign cb.applied = applied_r;

    // Fault level equals polarity bit means fault; in the pair, input two faults on the other level
    assign one_bad = (pin_r[0] == applied_r[F_POL1]); // [R12]
    assign two_bad = (pin_r[1] == applied_r[F_POL2]); // [R13]
    assign pair_bad = (pin_r[0] == applied_r[F_PAIR_POL])
        | (pin_r[1] != applied_r[F_PAIR_POL]); // [R11]
    assign cb.input_one_fault = ~applied_r[F_BIST] & one_bad; // [R14]
    assign cb.input_two_fault = ~applied_r[F_BIST] & two_bad;
    assign cb.pair_fault = applied_r[F_BIST] & pair_bad;

    AST_POL_ONE: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        !applied_r[F_BIST] |-> cb.input_one_fault == (pin_r[0] == applied_r[F_POL1]))
        else $error("input one fault does not follow polarity");
    AST_POL_TWO: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        !applied_r[F_BIST] |-> cb.input_two_fault == (pin_r[1] == applied_r[F_POL2]))
        else $error("input two fault does not follow polarity");
    AST_PAIR_POL: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        applied_r[F_BIST] |-> cb.pair_fault == (applied_r[F_PAIR_POL] ?
        (pin_r[0] | ~pin_r[1]) : (~pin_r[0] | pin_r[1])))
        else $error("pair fault does not follow pair polarity");
    AST_MODE: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
        applied_r[F_BIST] |-> !cb.input_one_fault && !cb.input_two_fault)
        else $error("independent flags active in bistable mode");
    AST_APPLY: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
        match == 4'hF |=> applied_r == $past(cb.cfg_fields))
        else $error("matching setting not applied");
    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
        ((applied_r ^ $past(applied_r)) & ~$past(match)) == 4'h0)
        else $error("mismatched setting changed evaluation");
    COV_BIST_FAULT: cover property (@(posedge pclk) disable iff (!presetn)
        cb.pair_fault);
endmodule

// ===== ssfc_fcu_model.sv
// Purpose: stand-in for the external controller driving both fault pins
// Assumes: pins change only just after a pclk edge
// Notes: slow mode adds one cycle of lag, as a busy controller might
`timescale 1ns/1ps
module ssfc_fcu_model
(
    input logic pclk,
    input logic presetn,
    input logic slow,
    input logic [1:0] want,
    output logic fault_input_one,
    output logic fault_input_two
);
    logic [1:0] lag_r;
    logic [1:0] pin_r;

    // Outputs sit low in reset, so the block sees faults at once
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lag_r <= 2'h0;
            pin_r <= 2'h0;
        end
        else
        begin
            lag_r <= want;
            pin_r <= slow ? lag_r : want;
        end
    end

    // Bit 0 is input one, bit 1 is input two
    assign fault_input_one = pin_r[0];
    assign fault_input_two = pin_r[1];
endmodule

// ===== test_ssfc_top.sv
// Purpose: self-checking bench for the safety status and fault input block
// Assumes: zero-wait APB slave, 25 MHz pclk
// Notes: pins pass two sync stages, so checks wait a few cycles
`timescale 1ns/1ps
module test_ssfc_top;
    import ssfc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [14:0] rt_in = 15'h0;
    logic [6:0] ev = 7'h0;
    logic [1:0] want = 2'h3;
    logic slow = 1'b0;
    logic fi1;
    logic fi2;
    logic [31:0] rd;
    logic er;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    int ev_bit [7] = '{0, 1, 4, 5, 5, 8, 9};
    logic [15:0] c_cfg [8] = '{16'h0, 16'h0, 16'h2000, 16'h1000,
        16'h0100, 16'h0100, 16'h4100, 16'h4100};
    logic [1:0] c_pin [8] = '{2'h3, 2'h0, 2'h3, 2'h3, 2'h1, 2'h3, 2'h2, 2'h3};
    logic [15:0] c_sts [8] = '{16'h0, 16'h6000, 16'h2000, 16'h4000,
        16'h0, 16'h1000, 16'h0, 16'h1000};

    ssfc_top u_ssfc_top
    (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .conv_two_current_limit_now(rt_in[14]), .conv_one_current_limit_now(rt_in[13]),
        .thermal_shutdown_now(rt_in[12]), .conv_two_undervoltage_now(rt_in[11]),
        .conv_one_undervoltage_now(rt_in[10]), .ext_monitor_undervoltage_now(rt_in[9:6]),
        .conv_two_overvoltage_now(rt_in[5]), .conv_one_overvoltage_now(rt_in[4]),
        .ext_monitor_overvoltage_now(rt_in[3:0]),
        .fault_input_one(fi1), .fault_input_two(fi2),
        .error_monitor_one_in(ev[5]), .error_monitor_two_in(ev[6]),
        .wd_closed_write(ev[4]), .wd_timeout(ev[3]), .wd_bad_answer(ev[2]),
        .bus_crc_error(ev[1]), .bus_request_error(ev[0]), .irq(irq)
    );

    ssfc_fcu_model u_ssfc_fcu_model
    (
        .pclk(pclk), .presetn(presetn), .slow(slow), .want(want),
        .fault_input_one(fi1), .fault_input_two(fi2)
    );

    // Free-running bus clock
    initial
    begin
        forever #20 pclk = ~pclk;
    end

    // Hang guard, far beyond the few hundred cycles the run needs
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        check("irq in reset", 32'h0, {31'h0, irq});
        presetn <= 1'b1;
    endtask

    task automatic t_reset_vals();
        rd_chk(OFS_CFG, 32'h0, "cfg reset");
        rd_chk(OFS_NCFG, 32'h7100, "ncfg reset");
        rd_chk(OFS_MASK, 32'h0, "mask reset");
        rd_chk(OFS_APPLIED, 32'h0, "applied reset");
        rd_chk(OFS_RT, 32'h0, "rt reset");
        repeat (6) @(posedge pclk);
        apb(1'b1, OFS_STS, 32'hFFFF);
        rd_chk(OFS_STS, 32'h0, "sts cleared");
    endtask

    // Walk a one across every realtime input
    task automatic t_realtime();
        for (int i = 0; i < 15; i++)
        begin
            rt_in <= 15'h1 << i;
            repeat (4) @(posedge pclk);
            rd_chk(OFS_RT, 32'h1 << i, "rt bit");
        end
        rt_in <= 15'h0;
    endtask

    // Each event source sets its sticky bit, the two watchdog timing sources sharing bit 5; a one clears it
    task automatic t_events();
        for (int i = 0; i < 7; i++)
        begin
            @(posedge pclk);
            ev[i] <= 1'b1;
            @(posedge pclk);
            ev[i] <= 1'b0;
            repeat (4) @(posedge pclk);
            rd_chk(OFS_STS, 32'h1 << ev_bit[i], "sts event");
            apb(1'b1, OFS_STS, 32'h1 << ev_bit[i]);
            rd_chk(OFS_STS, 32'h0, "sts w1c");
        end
    endtask

    task automatic t_irq();
        apb(1'b1, OFS_MASK, 32'h0010);
        rd_chk(OFS_MASK, 32'h0010, "mask rw");
        @(posedge pclk);
        ev[0] <= 1'b1;
        @(posedge pclk);
        ev[0] <= 1'b0;
        repeat (3) @(posedge pclk);
        check("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, OFS_STS, 32'h0001);
        ev[2] <= 1'b1;
        @(posedge pclk);
        ev[2] <= 1'b0;
        repeat (3) @(posedge pclk);
        check("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, OFS_STS, 32'h0010);
        repeat (2) @(posedge pclk);
        check("irq cleared", 32'h0, {31'h0, irq});
    endtask

    // Polarity and pair modes against pin levels, written consistently
    task automatic t_cfg();
        for (int i = 0; i < 8; i++)
        begin
            slow <= i[0];
            apb(1'b1, OFS_CFG, {16'h0, c_cfg[i]});
            apb(1'b1, OFS_NCFG, {16'h0, ~c_cfg[i] & 16'h7100});
            want <= c_pin[i];
            repeat (8) @(posedge pclk);
            apb(1'b1, OFS_STS, 32'hFFFF);
            repeat (6) @(posedge pclk);
            rd_chk(OFS_STS, {16'h0, c_sts[i]}, "fault sts");
            rd_chk(OFS_APPLIED, {16'h0, c_cfg[i]}, "applied");
        end
    endtask

    // Unmatched write must leave the pair setting in force
    task automatic t_hold();
        apb(1'b1, OFS_CFG, 32'h0);
        repeat (4) @(posedge pclk);
        rd_chk(OFS_APPLIED, 32'h4100, "applied held");
        apb(1'b1, OFS_STS, 32'hFFFF);
        repeat (6) @(posedge pclk);
        rd_chk(OFS_STS, 32'h1000, "held eval");
        rd_chk(OFS_NCFG, 32'h3000, "ncfg readback");
    endtask

    task automatic t_bus();
        rd_chk(8'h18, 32'h0, "unmapped data");
        check("unmapped err", 32'h1, {31'h0, er});
        apb(1'b1, OFS_RT, 32'hFFFF);
        rd_chk(OFS_RT, 32'h0, "rt read only");
        check("rt no err", 32'h0, {31'h0, er});
    endtask

    task automatic t_midreset();
        apb(1'b1, OFS_CFG, 32'h2000);
        apb(1'b1, OFS_NCFG, 32'h5100);
        do_reset();
        want <= 2'h3;
        t_reset_vals();
    endtask

    initial
    begin
        do_reset();
        t_reset_vals();
        t_realtime();
        t_events();
        t_irq();
        t_cfg();
        t_hold();
        t_bus();
        t_midreset();
        report_and_stop();
    end
endmodule
